// *** verilog/eac_pkg.sv ***
// constants shared by both ends of the storage access link
package eac_pkg;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned STORE_DEPTH = 1024;
	// i/o register offsets on the link
	localparam logic [1:0] IO_CONTROL = 2'h0;
	localparam logic [1:0] IO_DATA = 2'h1;
	localparam logic [1:0] IO_ADDR_LOW = 2'h2;
	localparam logic [1:0] IO_ADDR_HIGH = 2'h3;
	// control register bit positions
	localparam int unsigned CTL_READ_EN = 0;
	localparam int unsigned CTL_STROBE = 1;
	localparam int unsigned CTL_MWE = 2;
	localparam int unsigned CTL_RIE = 3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// timing
	localparam int unsigned ARM_WINDOW_CYCLES = 4;
	localparam int unsigned WRITE_STALL_CYCLES = 2;
	localparam int unsigned READ_STALL_CYCLES = 4;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned OSC_HZ = 1_000_000;
	localparam int unsigned WRITE_OSC_CYCLES = 8448;
	localparam int unsigned WRITE_TIME_US = 8500;
	localparam int unsigned WRITE_CLK_CYCLES = WRITE_OSC_CYCLES * (CLK_HZ / OSC_HZ);
	// apb register map of the controller
	localparam logic [11:0] APB_CMD = 12'h000;
	localparam logic [11:0] APB_ADDR = 12'h004;
	localparam logic [11:0] APB_WDATA = 12'h008;
	localparam logic [11:0] APB_RDATA = 12'h00c;
	localparam logic [11:0] APB_STATUS = 12'h010;
	localparam logic [11:0] APB_IRQ_STAT = 12'h014;
	localparam logic [11:0] APB_IRQ_MASK = 12'h018;
	localparam logic [11:0] APB_CONFIG = 12'h01c;
	localparam int unsigned CMD_WRITE = 0;
	localparam int unsigned CMD_READ = 1;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_READY = 1;
endpackage

// *** verilog/eac_io_if.sv ***
// link between the cpu-side controller and the storage device
`timescale 1ns/1ns
interface eac_io_if;
	logic io_wr;
	logic io_rd;
	logic [1:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic stall;
	logic ready_irq;
	logic global_ie;
	logic self_program_busy;
	modport device (
		input io_wr, io_rd, io_addr, io_wdata, global_ie, self_program_busy,
		output io_rdata, stall, ready_irq
	);
	modport host (
		output io_wr, io_rd, io_addr, io_wdata, global_ie, self_program_busy,
		input io_rdata, stall, ready_irq
	);
endinterface

// *** verilog/eac_down_timer.sv ***
// loadable down counter, busy while nonzero
`timescale 1ns/1ns
module eac_down_timer #(
	parameter int unsigned W = 4
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy,
	output logic o_done
);
	logic [W-1:0] cnt_q;

	assign o_busy = (cnt_q != '0);
	assign o_done = i_ce && !i_load && (cnt_q == W'(1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			if (i_load) begin
				cnt_q <= i_count;
			end else if (o_busy) begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end
endmodule

// *** verilog/eac_device.sv ***
// storage device end: i/o registers, byte store and write timing
`timescale 1ns/1ns
// What this block does
// - 1024 bytes, linear addresses, byte access
// - ten-bit address, high byte holds bits 9..8
// - unused address and control bits read zero
// - software loads address before any access
// - data register carries write and read bytes
// - ready interrupt while strobe clear and enabled
// - strobe starts write only within arm window
// - master write enable self-clears after four cycles
// - software polls, loads, arms, then strobes
// - no write during flash self-programming
// - strobe stays set until write completes
// - write lasts 8448 oscillator periods
// - write start stalls cpu two cycles
// - read fetches byte, stalls four cycles
// - busy write ignores reads and address changes
// - interrupts stay off during write sequence
module eac_device #(
	parameter int unsigned P_WRITE_CYCLES = eac_pkg::WRITE_CLK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	eac_io_if.device io,
	output logic o_write_busy,
	output logic o_write_done
);
	localparam int unsigned WT_W = $clog2(P_WRITE_CYCLES + 1);
	localparam int unsigned ST_W = 3;
	localparam int unsigned AW = eac_pkg::ADDR_W;

	// offset match on the link, shared by write decode and read mux
	function automatic logic io_sel(input logic [1:0] a, input logic [1:0] code);
		return a == code;
	endfunction

	// byte store
	logic [7:0] store_q [eac_pkg::STORE_DEPTH];
	logic [AW-1:0] addr_q;
	logic [7:0] data_q;
	logic rie_q;
	logic [7:0] rdata_q;

	logic arm_busy;
	logic write_busy;
	logic stall_busy;

	// accesses land only while the cpu is not halted
	wire wr_ok = io.io_wr && !stall_busy && i_ce;
	wire rd_ok = io.io_rd && !stall_busy && i_ce;
	wire ctl_wr = wr_ok && io_sel(io.io_addr, eac_pkg::IO_CONTROL);
	wire data_wr = wr_ok && io_sel(io.io_addr, eac_pkg::IO_DATA);
	wire alo_wr = wr_ok && io_sel(io.io_addr, eac_pkg::IO_ADDR_LOW);
	wire ahi_wr = wr_ok && io_sel(io.io_addr, eac_pkg::IO_ADDR_HIGH);

	wire wd_rie = io.io_wdata[eac_pkg::CTL_RIE];
	wire wd_mwe = io.io_wdata[eac_pkg::CTL_MWE];
	wire wd_strobe = io.io_wdata[eac_pkg::CTL_STROBE];
	wire wd_read = io.io_wdata[eac_pkg::CTL_READ_EN];

	// write starts only while armed, idle and no flash programming
	wire write_start = ctl_wr && wd_strobe && arm_busy && !write_busy
		&& !io.self_program_busy;
	wire read_start = ctl_wr && wd_read && !write_busy;

	// arming: set loads the window, writing zero clears it
	wire arm_load = ctl_wr && (wd_mwe ? !arm_busy : 1'b1);
	wire [2:0] arm_count = wd_mwe ? 3'(eac_pkg::ARM_WINDOW_CYCLES) : 3'h0;

	wire stall_load = write_start || read_start;
	wire [ST_W-1:0] stall_count = read_start ? ST_W'(eac_pkg::READ_STALL_CYCLES)
		: ST_W'(eac_pkg::WRITE_STALL_CYCLES);

	wire [7:0] ctl_view;
	wire [7:0] ahi_view;
	wire [7:0] rd_mux;
	wire [7:0] fetch_byte;
	wire ready_level;

	assign ctl_view = {4'h0, rie_q, arm_busy, write_busy, 1'b0};
	assign ahi_view = {6'h00, addr_q[9:8]};

	assign rd_mux = io_sel(io.io_addr, eac_pkg::IO_CONTROL) ? ctl_view
		: io_sel(io.io_addr, eac_pkg::IO_DATA) ? data_q
		: io_sel(io.io_addr, eac_pkg::IO_ADDR_LOW) ? addr_q[7:0]
		: ahi_view;

	// byte at the current address, fetched by a read strobe
	assign fetch_byte = store_q[addr_q];
	// level request, no flag: it follows the strobe bit directly
	assign ready_level = rie_q && io.global_ie && !write_busy;

	// master write enable window
	eac_down_timer #(
		.W(3)
	) u_arm (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_load(arm_load),
		.i_count(arm_count),
		.o_busy(arm_busy),
		.o_done()
	);

	// self-timed programming cycle
	eac_down_timer #(
		.W(WT_W)
	) u_write (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_load(write_start),
		.i_count(WT_W'(P_WRITE_CYCLES)),
		.o_busy(write_busy),
		.o_done(o_write_done)
	);

	// cpu halt after an access
	eac_down_timer #(
		.W(ST_W)
	) u_stall (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_load(stall_load),
		.i_count(stall_count),
		.o_busy(stall_busy),
		.o_done()
	);

	assign io.stall = stall_busy;
	assign io.io_rdata = rdata_q;
	assign io.ready_irq = ready_level;
	assign o_write_busy = write_busy;

	// address pair, frozen during a write
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_q <= '0;
		end else if (!write_busy) begin
			if (alo_wr) begin
				addr_q[7:0] <= io.io_wdata;
			end else if (ahi_wr) begin
				addr_q[9:8] <= io.io_wdata[1:0];
			end
		end
	end

	// data register: cpu load or read fetch
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			data_q <= 8'h00;
		end else if (read_start) begin
			data_q <= fetch_byte;
		end else if (data_wr) begin
			data_q <= io.io_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rie_q <= eac_pkg::CTL_RESET[eac_pkg::CTL_RIE];
		end else if (ctl_wr) begin
			rie_q <= wd_rie;
		end
	end

	// byte is committed at the strobe; the address is then held during the write, the data register is not
	always_ff @(posedge i_clk) begin
		if (write_start) begin
			store_q[addr_q] <= data_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
		end else if (rd_ok) begin
			rdata_q <= rd_mux;
		end
	end
endmodule

// *** verilog/eac_host.sv ***
// cpu-side controller: apb registers driving the storage link
`timescale 1ns/1ns
module eac_host (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	input wire logic i_self_program_busy,
	eac_io_if.host io
);
	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_POLL = 11'h002,
		S_CHECK = 11'h004,
		S_ADDR_HI = 11'h008,
		S_ADDR_LO = 11'h010,
		S_DATA = 11'h020,
		S_ARM = 11'h040,
		S_STROBE = 11'h080,
		S_READ_EN = 11'h100,
		S_READ_DATA = 11'h200,
		S_CAPTURE = 11'h400
	} eac_state_type;

	eac_state_type state_q, state_d;
	logic [9:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic op_write_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic gie_q;
	logic rie_q;
	logic [31:0] prdata_q;

	wire go = !io.stall && i_ce;
	wire idle = (state_q == S_IDLE);
	wire setup = i_psel && !i_penable;
	wire wr = i_psel && i_penable && i_pwrite && i_ce;
	wire hit = (i_paddr[11:5] == 7'h00) && (i_paddr[1:0] == 2'h0);
	wire cmd_wr = wr && (i_paddr == eac_pkg::APB_CMD) && idle;
	wire start_wr = cmd_wr && i_pwdata[eac_pkg::CMD_WRITE];
	wire start_rd = cmd_wr && !i_pwdata[eac_pkg::CMD_WRITE] && i_pwdata[eac_pkg::CMD_READ];
	wire op_done = go && ((state_q == S_STROBE) || (state_q == S_CAPTURE));
	wire [1:0] stat_set = {io.ready_irq, op_done};
	wire [1:0] stat_clr = (wr && i_paddr == eac_pkg::APB_IRQ_STAT) ? i_pwdata[1:0] : 2'h0;
	wire [7:0] mwe_bit = 8'h01 << eac_pkg::CTL_MWE;
	wire [7:0] strobe_bit = 8'h01 << eac_pkg::CTL_STROBE;
	wire [7:0] read_bit = 8'h01 << eac_pkg::CTL_READ_EN;
	// ready interrupt enable rides along on every control write
	wire [7:0] rie_bit = rie_q ? (8'h01 << eac_pkg::CTL_RIE) : 8'h00;
	wire issue_wr = state_q inside {S_ADDR_HI, S_ADDR_LO, S_DATA, S_ARM, S_STROBE, S_READ_EN};
	wire issue_rd = state_q inside {S_POLL, S_READ_DATA};
	logic [31:0] rd_mux;

	assign io.io_wr = issue_wr && go;
	assign io.io_rd = issue_rd && go;
	assign io.io_addr = (state_q == S_ADDR_HI) ? eac_pkg::IO_ADDR_HIGH
		: (state_q == S_ADDR_LO) ? eac_pkg::IO_ADDR_LOW
		: (state_q inside {S_DATA, S_READ_DATA}) ? eac_pkg::IO_DATA
		: eac_pkg::IO_CONTROL;
	// arm writes the strobe as zero; strobe keeps the arm bit set
	assign io.io_wdata = (state_q == S_ADDR_HI) ? {6'h00, addr_q[9:8]}
		: (state_q == S_ADDR_LO) ? addr_q[7:0]
		: (state_q == S_DATA) ? wdata_q
		: (state_q == S_ARM) ? (mwe_bit | rie_bit)
		: (state_q == S_STROBE) ? (mwe_bit | strobe_bit | rie_bit)
		: (state_q == S_READ_EN) ? (read_bit | rie_bit)
		: 8'h00;
	// device interrupt held off for the whole sequence
	assign io.global_ie = gie_q && idle;
	assign io.self_program_busy = i_self_program_busy;

	assign o_pready = i_ce;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_prdata = prdata_q;
	assign o_irq = |(stat_q & mask_q);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_paddr)
			eac_pkg::APB_ADDR: rd_mux = {22'h0_0000, addr_q};
			eac_pkg::APB_WDATA: rd_mux = {24'h00_0000, wdata_q};
			eac_pkg::APB_RDATA: rd_mux = {24'h00_0000, rdata_q};
			eac_pkg::APB_STATUS: rd_mux = {30'h000_0000, io.ready_irq, !idle};
			eac_pkg::APB_IRQ_STAT: rd_mux = {30'h000_0000, stat_q};
			eac_pkg::APB_IRQ_MASK: rd_mux = {30'h000_0000, mask_q};
			eac_pkg::APB_CONFIG: rd_mux = {30'h000_0000, rie_q, gie_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: if (start_wr || start_rd) state_d = S_POLL;
			S_POLL: if (go) state_d = S_CHECK;
			// wait out a running write and any flash programming
			S_CHECK: if (i_ce) begin
				state_d = (io.io_rdata[eac_pkg::CTL_STROBE] || i_self_program_busy)
					? S_POLL : S_ADDR_HI;
			end
			S_ADDR_HI: if (go) state_d = S_ADDR_LO;
			S_ADDR_LO: if (go) state_d = op_write_q ? S_DATA : S_READ_EN;
			S_DATA: if (go) state_d = S_ARM;
			S_ARM: if (go) state_d = S_STROBE;
			S_STROBE: if (go) state_d = S_IDLE;
			S_READ_EN: if (go) state_d = S_READ_DATA;
			S_READ_DATA: if (go) state_d = S_CAPTURE;
			S_CAPTURE: if (i_ce) state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= S_IDLE;
			op_write_q <= 1'b0;
			rdata_q <= 8'h00;
		end else if (i_ce) begin
			state_q <= state_d;
			if (start_wr || start_rd) op_write_q <= start_wr;
			if (state_q == S_CAPTURE) rdata_q <= io.io_rdata;
		end
	end

	// software registers; address and data locked while busy
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_q <= 10'h000;
			wdata_q <= 8'h00;
			mask_q <= 2'h0;
			gie_q <= 1'b0;
			rie_q <= 1'b0;
		end else if (wr) begin
			if (i_paddr == eac_pkg::APB_ADDR && idle) addr_q <= i_pwdata[9:0];
			if (i_paddr == eac_pkg::APB_WDATA && idle) wdata_q <= i_pwdata[7:0];
			if (i_paddr == eac_pkg::APB_IRQ_MASK) mask_q <= i_pwdata[1:0];
			if (i_paddr == eac_pkg::APB_CONFIG) gie_q <= i_pwdata[0];
			if (i_paddr == eac_pkg::APB_CONFIG) rie_q <= i_pwdata[1];
		end
	end

	// sticky events, set wins over write-one clear
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stat_q <= 2'h0;
			prdata_q <= 32'h0000_0000;
		end else if (i_ce) begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
			if (setup) prdata_q <= rd_mux;
		end
	end
endmodule

// *** verif/eac_asserts.sv ***
// concurrent checks on the storage link between host and device
`timescale 1ns/1ns
module eac_asserts #(
	parameter int unsigned P_WRITE_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic io_wr,
	input wire logic [1:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic stall,
	input wire logic ready_irq,
	input wire logic global_ie,
	input wire logic self_program_busy,
	input wire logic o_write_busy,
	input wire logic o_write_done
);
	logic ctl_wr;
	logic [2:0] age_q;
	logic rie_q;
	logic [31:0] cnt_q;
	assign ctl_wr = io_wr && !stall && io_addr == eac_pkg::IO_CONTROL;
	// age of the arm window, 1..4 while a strobe may start a write
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			age_q <= 3'h0;
		end else if (ctl_wr && !io_wdata[2]) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h0) begin
			age_q <= (age_q == 3'h4) ? 3'h0 : age_q + 3'h1;
		end else if (ctl_wr) begin
			age_q <= 3'h1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rie_q <= 1'b0;
			cnt_q <= 32'h0000_0000;
		end else begin
			rie_q <= ctl_wr ? io_wdata[3] : rie_q;
			cnt_q <= o_write_busy ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	read_stall_a: assert property (ctl_wr && io_wdata[0] && !o_write_busy |=> stall[*4] ##1 !stall)
		else $error("read did not stall four cycles");
	write_stall_a: assert property ($rose(o_write_busy) |-> stall ##1 stall ##1 !stall)
		else $error("write start did not stall two cycles");
	write_time_a: assert property ($fell(o_write_busy) |-> cnt_q == P_WRITE_CYCLES)
		else $error("programming time wrong");
	busy_hold_a: assert property ($rose(o_write_busy) |-> o_write_busy[*8])
		else $error("busy dropped early");
	done_pulse_a: assert property ($fell(o_write_busy) |-> $past(o_write_done))
		else $error("no done pulse at end of write");
	arm_window_a: assert property ($rose(o_write_busy) |-> $past(age_q) != 3'h0)
		else $error("write started outside arm window");
	flash_block_a: assert property ($rose(o_write_busy) |-> !$past(self_program_busy))
		else $error("write started during self programming");
	ready_level_a: assert property (ready_irq == (rie_q && global_ie && !o_write_busy))
		else $error("ready interrupt level wrong");
	busy_read_a: assert property (o_write_busy && ctl_wr && io_wdata[0] |=> !stall)
		else $error("read accepted during write");
	cover property ($rose(o_write_busy));
	cover property ($fell(o_write_busy));
	cover property (ctl_wr && io_wdata[0]);
endmodule

// *** verif/testbench.sv ***
// self-checking bench: apb host driving the storage device over the link
`timescale 1ns/1ns
module testbench;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic spb = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic wbusy;
	logic wdone;
	logic [31:0] rd;
	logic [31:0] slv;
	logic [7:0] d;
	logic [7:0] mem [int];
	logic [9:0] adr [$];
	integer seed = 32'h5c71354d;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	eac_io_if link_inst();
	always #2 i_clk = ~i_clk;
	eac_device #(.P_WRITE_CYCLES(20)) eac_device_inst(.i_clk(i_clk), .i_rstn(i_rstn),
		.i_ce(1'b1), .io(link_inst), .o_write_busy(wbusy), .o_write_done(wdone));
	eac_host eac_host_inst(.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
		.i_self_program_busy(spb), .io(link_inst));
	eac_asserts #(.P_WRITE_CYCLES(20)) eac_asserts_inst(.i_clk(i_clk), .i_rstn(i_rstn),
		.io_wr(link_inst.io_wr), .io_addr(link_inst.io_addr), .io_wdata(link_inst.io_wdata),
		.stall(link_inst.stall), .ready_irq(link_inst.ready_irq),
		.global_ie(link_inst.global_ie), .self_program_busy(link_inst.self_program_busy),
		.o_write_busy(wbusy), .o_write_done(wdone));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	function logic [31:0] exp_rd(input logic [9:0] a);
		return {24'h00_0000, mem[a]};
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1) @(posedge i_clk);
		rd = prdata;
		slv = 32'(pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_bit(input logic [11:0] a, input logic v);
		int i;
		for (i = 0; i < 400; i++) begin
			apb(1'b0, a, 32'h0000_0000);
			if (rd[0] === v) break;
		end
		chk(32'(rd[0]), 32'(v));
	endtask
	task op(input logic [31:0] cmd, input logic [9:0] a, input logic [7:0] wd, input logic hold);
		wait_bit(eac_pkg::APB_STATUS, 1'b0);
		apb(1'b1, eac_pkg::APB_IRQ_STAT, 32'h0000_0001);
		apb(1'b1, eac_pkg::APB_ADDR, 32'(a));
		apb(1'b1, eac_pkg::APB_WDATA, 32'(wd));
		apb(1'b1, eac_pkg::APB_CMD, cmd);
		if (hold) begin
			repeat (60) @(posedge i_clk);
			apb(1'b0, eac_pkg::APB_IRQ_STAT, 32'h0000_0000);
			chk(rd & 32'h0000_0001, 32'h0000_0000);
			spb <= 1'b0;
		end
		wait_bit(eac_pkg::APB_IRQ_STAT, 1'b1);
	endtask
	task irq_chk(input logic [11:0] a, input logic [31:0] wd, input logic v);
		apb(1'b1, a, wd);
		@(negedge i_clk);
		chk(32'(irq), 32'(v));
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		apb(1'b0, eac_pkg::APB_IRQ_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		apb(1'b1, eac_pkg::APB_CONFIG, 32'h0000_0003);
		adr = {10'h000, 10'h3ff, 10'h100, 10'h0ff};
		repeat (6) adr.push_back(10'($random(seed)));
		foreach (adr[i]) begin
			d = 8'($random(seed));
			mem[adr[i]] = d;
			op(32'h0000_0001, adr[i], d, 1'b0);
		end
		foreach (adr[i]) begin
			op(32'h0000_0002, adr[i], 8'h00, 1'b0);
			apb(1'b0, eac_pkg::APB_RDATA, 32'h0000_0000);
			chk(rd, exp_rd(adr[i]));
		end
		apb(1'b0, eac_pkg::APB_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		irq_chk(eac_pkg::APB_IRQ_MASK, 32'h0000_0001, 1'b1);
		irq_chk(eac_pkg::APB_IRQ_MASK, 32'h0000_0000, 1'b0);
		irq_chk(eac_pkg::APB_IRQ_MASK, 32'h0000_0001, 1'b1);
		irq_chk(eac_pkg::APB_IRQ_STAT, 32'h0000_0001, 1'b0);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(slv, 32'h0000_0001);
		spb <= 1'b1;
		mem[10'h155] = 8'ha5;
		op(32'h0000_0001, 10'h155, 8'ha5, 1'b1);
		op(32'h0000_0002, 10'h155, 8'h00, 1'b0);
		apb(1'b0, eac_pkg::APB_RDATA, 32'h0000_0000);
		chk(rd, exp_rd(10'h155));
		end_sim();
	end
endmodule
